/* logic/spi_master_pkg.sv */
// shared constants and types for the serial master port
package spi_master_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int MAX_BITS = 32;
  localparam int SEL_COUNT = 5;
  localparam int DIV_SEL_W = 3;
  localparam int LEN_W = 5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [SEL_COUNT-1:0] SEL_RESET = 5'h1F;
  localparam logic [MAX_BITS-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [5:0] BITS_RESET = 6'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // transfer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b11,
    ST_DONE = 2'b10
  } xfer_state_type;
endpackage : spi_master_pkg

/* logic/pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb
  begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = level_reg;
    // second and third stages agree
    if (stage_reg[1] == stage_reg[2])
    begin
      level_next = stage_reg[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end
    else
    begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule : pin_sync

/* logic/spi_master_port.sv */
// serial peripheral master: shift engine, clock divider, selects
`timescale 1ns/1ps
module spi_master_port
#(
  parameter int MAX_BITS = spi_master_pkg::MAX_BITS,
  parameter int SEL_COUNT = spi_master_pkg::SEL_COUNT
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic START,
  input wire logic [spi_master_pkg::LEN_W-1:0] LENGTH_MINUS_ONE,
  input wire logic [MAX_BITS-1:0] TX_DATA,
  input wire logic [spi_master_pkg::DIV_SEL_W-1:0] DIV_SELECT,
  input wire logic CLK_POLARITY,
  input wire logic CLK_PHASE,
  input wire logic LSB_FIRST,
  input wire logic DELAYED_SAMPLE,
  input wire logic AUTO_SELECT,
  input wire logic [SEL_COUNT-1:0] SELECT_ENABLE,
  input wire logic DONE_CLEAR,
  input wire logic DONE_MASK,
  input wire logic master_in_line,
  output logic [MAX_BITS-1:0] RX_DATA,
  output logic BUSY,
  output logic DONE_STATUS,
  output logic DONE_IRQ,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  output logic master_out_line,
  output logic master_out_oe_n,
  output logic [SEL_COUNT-1:0] slave_select_line,
  output logic [SEL_COUNT-1:0] slave_select_oe_n,
  output logic PULLUP_ENABLE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  spi_master_pkg::xfer_state_type state_reg, state_next;
  logic [7:0] count_reg, count_next;
  logic [5:0] bits_reg, bits_next;
  logic [MAX_BITS-1:0] tx_reg, tx_next;
  logic [MAX_BITS-1:0] rx_reg, rx_next;
  logic sclk_reg, sclk_next;
  logic mosi_reg, mosi_next;
  logic [SEL_COUNT-1:0] sel_reg, sel_next;
  logic done_reg, done_next;
  logic lsb_reg, lsb_next;
  logic cpol_reg, cpol_next;
  logic cpha_reg, cpha_next;
  logic dly_reg, dly_next;
  logic auto_reg, auto_next;
  logic [2:0] div_reg, div_next;
  logic [5:0] len_reg, len_next;
  logic drive_reg, drive_next;
  logic pend_reg, pend_next;
  logic [4:0] start_len_reg, start_len_next;
  logic miso_sync;
  logic [7:0] half_count;
  logic half_tick;
  logic next_bit;

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  pin_sync miso_sync_inst
  (
    .clk(SYS_CLK),
    .rst(RST),
    .pin_in(master_in_line),
    .level_out(miso_sync)
  );

  // half period in system clocks: 2^div_select
  assign half_count = 8'h01 << div_reg;
  assign half_tick = (count_reg == half_count - 8'h01);
  // outgoing bit for the current position
  assign next_bit = lsb_reg ? tx_reg[0] : tx_reg[len_reg[4:0]];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    bits_next = bits_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    sclk_next = sclk_reg;
    mosi_next = mosi_reg;
    sel_next = sel_reg;
    done_next = done_reg;
    lsb_next = lsb_reg;
    cpol_next = cpol_reg;
    cpha_next = cpha_reg;
    dly_next = dly_reg;
    auto_next = auto_reg;
    div_next = div_reg;
    len_next = len_reg;
    drive_next = 1'b1;
    start_len_next = start_len_reg;
    // a pending delayed sample waits for the next half tick
    pend_next = pend_reg && !half_tick;
    if (!AUTO_SELECT)
      sel_next = ~SELECT_ENABLE;
    if (DONE_CLEAR)
      done_next = 1'b0;
    // delayed sample taken one half period after nominal edge
    if (pend_reg && half_tick)
    begin
      rx_next = lsb_reg ? {miso_sync, rx_reg[MAX_BITS-1:1]}
                        : {rx_reg[MAX_BITS-2:0], miso_sync};
    end
    unique case (state_reg)
      spi_master_pkg::ST_IDLE:
      begin
        sclk_next = CLK_POLARITY;
        if (START)
        begin
          lsb_next = LSB_FIRST;
          cpol_next = CLK_POLARITY;
          cpha_next = CLK_PHASE;
          dly_next = DELAYED_SAMPLE;
          auto_next = AUTO_SELECT;
          div_next = DIV_SELECT;
          len_next = {1'b0, LENGTH_MINUS_ONE};
          tx_next = TX_DATA;
          rx_next = spi_master_pkg::DATA_RESET;
          bits_next = spi_master_pkg::BITS_RESET;
          count_next = spi_master_pkg::COUNT_RESET;
          start_len_next = LENGTH_MINUS_ONE;
          if (AUTO_SELECT)
            sel_next = ~SELECT_ENABLE;
          // phase 0 presents data before the first edge
          if (!CLK_PHASE)
            mosi_next = LSB_FIRST ? TX_DATA[0]
                                  : TX_DATA[LENGTH_MINUS_ONE];
          state_next = spi_master_pkg::ST_LEAD;
        end
      end
      spi_master_pkg::ST_LEAD:
      begin
        count_next = count_reg + 8'h01;
        if (half_tick)
        begin
          count_next = spi_master_pkg::COUNT_RESET;
          sclk_next = ~cpol_reg;
          if (cpha_reg)
            mosi_next = next_bit;
          else if (dly_reg)
            pend_next = 1'b1;
          else
            rx_next = lsb_reg ? {miso_sync, rx_reg[MAX_BITS-1:1]}
                              : {rx_reg[MAX_BITS-2:0], miso_sync};
          state_next = spi_master_pkg::ST_TRAIL;
        end
      end
      spi_master_pkg::ST_TRAIL:
      begin
        count_next = count_reg + 8'h01;
        if (half_tick)
        begin
          count_next = spi_master_pkg::COUNT_RESET;
          sclk_next = cpol_reg;
          tx_next = lsb_reg ? (tx_reg >> 1) : tx_reg;
          if (cpha_reg && dly_reg)
            pend_next = 1'b1;
          else if (cpha_reg)
            rx_next = lsb_reg ? {miso_sync, rx_reg[MAX_BITS-1:1]}
                              : {rx_reg[MAX_BITS-2:0], miso_sync};
          bits_next = bits_reg + 6'h01;
          if (bits_reg[4:0] == start_len_reg)
          begin
            state_next = spi_master_pkg::ST_DONE;
          end
          else
          begin
            if (!lsb_reg)
              len_next = len_reg - 6'h01;
            if (!cpha_reg)
            begin
              mosi_next = lsb_reg ? tx_reg[1]
                                  : tx_reg[5'(len_reg - 6'h01)];
            end
            state_next = spi_master_pkg::ST_LEAD;
          end
        end
      end
      spi_master_pkg::ST_DONE:
      begin
        // wait for a pending delayed sample to land
        count_next = count_reg + 8'h01;
        if (!pend_reg)
        begin
          count_next = spi_master_pkg::COUNT_RESET;
          done_next = 1'b1;
          if (auto_reg)
            sel_next = spi_master_pkg::SEL_RESET;
          state_next = spi_master_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg <= spi_master_pkg::ST_IDLE;
      count_reg <= spi_master_pkg::COUNT_RESET;
      bits_reg <= spi_master_pkg::BITS_RESET;
      tx_reg <= spi_master_pkg::DATA_RESET;
      rx_reg <= spi_master_pkg::DATA_RESET;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
      sel_reg <= spi_master_pkg::SEL_RESET;
      done_reg <= 1'b0;
      lsb_reg <= 1'b0;
      cpol_reg <= 1'b0;
      cpha_reg <= 1'b0;
      dly_reg <= 1'b0;
      auto_reg <= 1'b0;
      div_reg <= 3'h0;
      len_reg <= spi_master_pkg::BITS_RESET;
      drive_reg <= 1'b0;
      pend_reg <= 1'b0;
      start_len_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      bits_reg <= bits_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      sclk_reg <= sclk_next;
      mosi_reg <= mosi_next;
      sel_reg <= sel_next;
      done_reg <= done_next;
      lsb_reg <= lsb_next;
      cpol_reg <= cpol_next;
      cpha_reg <= cpha_next;
      dly_reg <= dly_next;
      auto_reg <= auto_next;
      div_reg <= div_next;
      len_reg <= len_next;
      drive_reg <= drive_next;
      pend_reg <= pend_next;
      start_len_reg <= start_len_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // received word right-aligned for MSB first
  assign RX_DATA = rx_reg;
  assign BUSY = (state_reg != spi_master_pkg::ST_IDLE);
  assign DONE_STATUS = done_reg;
  assign DONE_IRQ = done_reg & ~DONE_MASK;
  assign serial_clock_out = sclk_reg;
  assign master_out_line = mosi_reg;
  assign slave_select_line = sel_reg;
  // released under reset, pull-ups on
  assign serial_clock_oe_n = ~drive_reg;
  assign master_out_oe_n = ~drive_reg;
  assign slave_select_oe_n = {SEL_COUNT{~drive_reg}};
  assign PULLUP_ENABLE = ~drive_reg;
endmodule : spi_master_port

/* tb/spi_slave_model.sv */
// behavioural serial slave answering with the inverse of what it hears
`timescale 1ns/1ps
module spi_slave_model
(
  input wire logic mosi,
  input wire logic mosi_oe_n,
  input wire logic [4:0] sel_n,
  output logic miso
);
  // ----------------------------------------
  // released line floats to its pull-up level
  // ----------------------------------------
  // answers only while selected and driven by the master
  assign miso = (&sel_n || mosi_oe_n) ? 1'b1 : ~mosi;
endmodule : spi_slave_model

/* tb/spi_master_port_asserts.sv */
// concurrent checks on the serial master port pins
`timescale 1ns/1ps
module spi_master_port_chk
#(
  parameter int SEL_COUNT = 5
)
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic START,
  input wire logic [spi_master_pkg::LEN_W-1:0] LENGTH_MINUS_ONE,
  input wire logic CLK_POLARITY,
  input wire logic CLK_PHASE,
  input wire logic AUTO_SELECT,
  input wire logic [SEL_COUNT-1:0] SELECT_ENABLE,
  input wire logic DONE_CLEAR,
  input wire logic BUSY,
  input wire logic DONE_STATUS,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe_n,
  input wire logic master_out_line,
  input wire logic master_out_oe_n,
  input wire logic [SEL_COUNT-1:0] slave_select_line,
  input wire logic PULLUP_ENABLE
);
  logic [6:0] edge_cnt_reg;
  logic [5:0] len_reg;
  logic clk_d_reg;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // ----------------------------------------
  // serial clock edges per transfer
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    clk_d_reg <= serial_clock_out;
    if (START && !BUSY)
    begin
      edge_cnt_reg <= 7'h00;
      len_reg <= {1'b0, LENGTH_MINUS_ONE} + 6'h01;
    end
    else if (serial_clock_out != clk_d_reg)
      edge_cnt_reg <= edge_cnt_reg + 7'h01;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_reset_float: assert property (disable iff (1'b0)
    RST && $past(RST) |-> PULLUP_ENABLE && serial_clock_oe_n
    && master_out_oe_n) else $error("lines not released in reset");
  chk_drive_after: assert property (!$past(RST) |->
    !serial_clock_oe_n && !master_out_oe_n)
    else $error("master not driving");
  chk_idle_level: assert property (!BUSY && !$past(BUSY) &&
    !$past(RST) && $stable(CLK_POLARITY) |->
    serial_clock_out == CLK_POLARITY) else $error("idle level wrong");
  chk_shift_edge: assert property (BUSY && $changed(serial_clock_out)
    && ((serial_clock_out != CLK_POLARITY) != CLK_PHASE) |->
    $stable(master_out_line)) else $error("data moved on sample edge");
  chk_edge_count: assert property ($fell(BUSY) |-> ##2
    edge_cnt_reg == {len_reg, 1'b0}) else $error("clock edge count");
  chk_auto_select: assert property (AUTO_SELECT && BUSY && $past(BUSY)
    |-> slave_select_line == ~SELECT_ENABLE) else $error("auto select");
  chk_auto_release: assert property (AUTO_SELECT && $past(AUTO_SELECT)
    && !BUSY && !$past(BUSY) && !$past(RST) |-> &slave_select_line)
    else $error("select not released");
  chk_manual_select: assert property (!AUTO_SELECT &&
    !$past(AUTO_SELECT) && $stable(SELECT_ENABLE) && !$past(RST)
    |-> slave_select_line == ~SELECT_ENABLE) else $error("manual select");
  chk_done_after: assert property ($fell(BUSY) |-> ##[0:2] DONE_STATUS)
    else $error("done not raised");
  chk_done_sticky: assert property (DONE_STATUS && !DONE_CLEAR |=>
    DONE_STATUS) else $error("done lost");
  cov_mode3: cover property ($fell(BUSY) && CLK_POLARITY && CLK_PHASE);
  cov_manual: cover property ($fell(BUSY) && !AUTO_SELECT);
  cov_clear: cover property (DONE_STATUS && DONE_CLEAR);
endmodule : spi_master_port_chk
bind spi_master_port spi_master_port_chk #(.SEL_COUNT(SEL_COUNT)) u_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .START(START),
  .LENGTH_MINUS_ONE(LENGTH_MINUS_ONE), .CLK_POLARITY(CLK_POLARITY),
  .CLK_PHASE(CLK_PHASE), .AUTO_SELECT(AUTO_SELECT),
  .SELECT_ENABLE(SELECT_ENABLE), .DONE_CLEAR(DONE_CLEAR), .BUSY(BUSY),
  .DONE_STATUS(DONE_STATUS), .serial_clock_out(serial_clock_out),
  .serial_clock_oe_n(serial_clock_oe_n), .master_out_line(master_out_line),
  .master_out_oe_n(master_out_oe_n), .slave_select_line(slave_select_line),
  .PULLUP_ENABLE(PULLUP_ENABLE));

/* tb/tb_spi_master_port.sv */
// self-checking bench for the serial master port
`timescale 1ns/1ps
`define CHK(a, b, m) \
  begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t %s", $time, m); \
    end \
  end
module tb_spi_master_port;
  typedef struct {logic [31:0] val; logic [31:0] msk; int cyc; logic irq;}
    note_type;
  logic sys_clk, rst, start, cpol, cpha, lsb, dly, auto_sel, dclr, dmask;
  logic busy, done, irq, sclk, sclk_oe_n, mosi, mosi_oe_n, miso, pull;
  logic [4:0] len_m1, sel_en, sel_n, sel_oe_n;
  logic [31:0] tx, rx;
  logic [2:0] div;
  logic [31:0] seed = 32'h2970;
  logic done_d = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  note_type note_q[$];
  note_type nt;
  spi_master_port uut (.SYS_CLK(sys_clk), .RST(rst), .START(start),
    .LENGTH_MINUS_ONE(len_m1), .TX_DATA(tx), .DIV_SELECT(div),
    .CLK_POLARITY(cpol), .CLK_PHASE(cpha), .LSB_FIRST(lsb),
    .DELAYED_SAMPLE(dly), .AUTO_SELECT(auto_sel), .SELECT_ENABLE(sel_en),
    .DONE_CLEAR(dclr), .DONE_MASK(dmask), .master_in_line(miso),
    .RX_DATA(rx), .BUSY(busy), .DONE_STATUS(done), .DONE_IRQ(irq),
    .serial_clock_out(sclk), .serial_clock_oe_n(sclk_oe_n),
    .master_out_line(mosi), .master_out_oe_n(mosi_oe_n),
    .slave_select_line(sel_n), .slave_select_oe_n(sel_oe_n),
    .PULLUP_ENABLE(pull));
  spi_slave_model peer (.mosi(mosi), .mosi_oe_n(mosi_oe_n),
    .sel_n(sel_n), .miso(miso));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic test_done;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    done_d <= done;
    cyc <= (start && !busy) ? 0 : cyc + 1;
    if (done && !done_d)
    begin
      nt = note_q.pop_front();
      `CHK(rx & nt.msk, nt.val, "rx data")
      `CHK(irq, nt.irq, "irq level")
      `CHK(cyc >= nt.cyc && cyc <= nt.cyc + 4, 1'b1, "duration")
    end
  end
  // ----------------------------------------
  // driver: one transfer, dummy data read back
  // ----------------------------------------
  task automatic xfer(input int i, input int n, input logic au);
    int k;
    note_type e;
    seed = lfsr(seed);
    if (n == 0)
      n = seed[4:0] + 1;
    @(posedge sys_clk);
    len_m1 <= 5'(n - 1);
    tx <= seed;
    div <= 3'(i % 8);
    {cpol, cpha} <= 2'(i % 4);
    lsb <= i[2];
    dly <= (i >= 8);
    dmask <= i[0];
    auto_sel <= au;
    sel_en <= au ? 5'(5'h1F >> (i % 5)) : 5'h01;
    e.msk = 32'hFFFF_FFFF >> (32 - n);
    e.val = ~seed & e.msk;
    if (i[2])
    begin
      e.msk = e.msk << (32 - n);
      e.val = e.val << (32 - n);
    end
    if (i % 8 < 3)
      e.msk = 32'h0;
    e.val = e.val & e.msk;
    e.cyc = n * (2 << (i % 8)) + ((i >= 8 && i[0]) ? (1 << (i % 8)) : 0);
    e.irq = ~i[0];
    repeat (2) @(posedge sys_clk);
    note_q.push_back(e);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    if (i == 5)
    begin
      repeat (10) @(posedge sys_clk);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
    end
    for (k = 0; k < 40000 && done !== 1'b1; k++)
      @(negedge sys_clk);
    if (k >= 40000)
    begin
      error_cnt++;
      test_done();
    end
    @(posedge sys_clk);
    dclr <= 1'b1;
    @(posedge sys_clk);
    dclr <= 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(done, 1'b0, "done not cleared")
    $display("test transfer %0d of %0d bits done", i, n);
  endtask : xfer
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    {start, cpol, cpha, lsb, dly, auto_sel, dclr, dmask} = 8'h00;
    len_m1 = 5'h00;
    tx = 32'h0000_0000;
    div = 3'h0;
    sel_en = 5'h00;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK({pull, sclk_oe_n, mosi_oe_n, sel_oe_n}, 8'hFF, "reset float")
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK({sclk_oe_n, mosi_oe_n, sel_oe_n}, 7'h00, "not driving")
    $display("test reset done");
    for (int i = 0; i < 12; i++)
      xfer(i, (i == 0) ? 1 : (i == 1) ? 32 : 0, 1'b1);
    xfer(3, 8, 1'b0);
    `CHK(sel_n, 5'h1E, "select dropped")
    xfer(3, 32, 1'b0);
    @(posedge sys_clk);
    sel_en <= 5'h00;
    repeat (2) @(negedge sys_clk);
    `CHK(sel_n, 5'h1F, "select held")
    `CHK(note_q.size(), 0, "missing result")
    $display("test manual select done");
    test_done();
  end
endmodule : tb_spi_master_port
